// ### core/uart_irq_ctrl.sv
// Purpose: interrupt enable, prioritised status and fifo control of one channel
// Assumes: all inputs synchronous to sys_clk_i; fifo levels supplied by the datapath
// Notes:   read data valid the cycle after rd_i; events are pulses from the datapath
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps

// How it works
// - tx irq follows holding-empty or below-trigger
// - half-duplex: tx irq when fifo and shifter empty
// - receive error bits raise line irq immediately
// - modem status bits 0-3 raise modem irq
// - enable bits 7:5 need enhanced bit 4
// - selected rts/dtr rising edge interrupts
// - selected cts/dsr rising edge interrupts
// - status read shows highest pending source only
// - codes for priority levels one to four
// - codes for levels five to seven, none
// - receive timeout after 4 chars plus 12 bits
// - line, modem, pin, tx, char clear by a read; timeout when rx fifo empties
// - xon/xoff clear on read; special also next char
// - wake-up flag, cleared by global source read
// - bit 0 low when pending, high otherwise
// - status bits 4,5 need enhanced bit 4
// - status bits 7:6 mirror fifo enable
// - fifo control bits 7:1 ignored unless bit 0 set
// - fifo reset bits pulse once, self-clear
// - block-transfer bit stored, no effect
// - tx trigger select, enhanced bit 4 only
// - last written trigger table applies both ways
module uart_irq_ctrl (
    // clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rstn_i,
    // register port
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    // datapath state
    input  wire logic [4:1] line_err_i,
    input  wire logic       rx_char_i,
    input  wire logic       rx_data_rdy_i,
    input  wire logic [6:0] rx_level_i,
    input  wire logic [6:0] rx_trigger_i,
    input  wire logic       bit_tick_i,
    input  wire logic       tx_hold_empty_i,
    input  wire logic [6:0] tx_level_i,
    input  wire logic       tx_shift_empty_i,
    input  wire logic [3:0] modem_delta_i,
    input  wire logic       rts_dtr_sel_i,
    input  wire logic       cts_dsr_sel_i,
    input  wire logic       xon_det_i,
    input  wire logic       xoff_det_i,
    input  wire logic       special_det_i,
    input  wire logic       wake_i,
    input  wire logic       global_src_rd_i,
    input  wire logic [7:0] modem_control_i,
    // fifo control outputs
    output logic            fifo_en_o,
    output logic            rx_fifo_rst_o,
    output logic            tx_fifo_rst_o,
    output logic            block_mode_o,
    output logic      [1:0] trig_table_o,
    output logic      [1:0] tx_trig_sel_o,
    // interrupt outputs
    output logic            chan_irq_o,
    output logic            wake_flag_o
);

    // software registers
    logic [7:0] interrupt_enable;
    logic [7:0] feature_control;
    logic [7:0] enhanced_feature;
    logic [7:0] tx_trigger_prog;
    logic [1:0] flow_char_indicator;
    logic       dtr_sel;

    // pending flags
    logic       line_pend;
    logic       modem_pend;
    logic       tx_pend;
    logic       char_pend;
    logic       pin_pend;
    logic       to_pend;
    logic xonoff_kind;
    logic rts_q, cts_q;
    logic [5:0] to_cnt;
    logic       tx_reloaded_over;
    logic [6:0] tx_trigger;
    logic [5:0] next_code;
    logic       enh;

    // decoded accesses
    logic       wr_en;
    logic       wr_fc;
    logic       wr_feat;
    logic       wr_enh;
    logic       wr_trg;
    logic rd_status, rd_line, rd_modem, rd_flow;

    assign wr_en     = wr_i && addr_i == uart_irq_pkg::ADDR_ENABLE;
    assign wr_fc     = wr_i && addr_i == uart_irq_pkg::ADDR_STATUS_FC;
    assign wr_feat   = wr_i && addr_i == uart_irq_pkg::ADDR_FEATURE;
    assign wr_enh    = wr_i && addr_i == uart_irq_pkg::ADDR_ENHANCED;
    assign wr_trg    = wr_i && addr_i == uart_irq_pkg::ADDR_TX_TRIG;
    assign rd_status = rd_i && addr_i == uart_irq_pkg::ADDR_STATUS_FC;
    assign rd_line   = rd_i && addr_i == uart_irq_pkg::ADDR_LINE_STAT;
    assign rd_modem  = rd_i && addr_i == uart_irq_pkg::ADDR_MODEM_STAT;
    assign rd_flow   = rd_i && addr_i == uart_irq_pkg::ADDR_FLOW_CHAR;
    assign enh       = enhanced_feature[uart_irq_pkg::EF_ENH];
    assign dtr_sel   = modem_control_i[uart_irq_pkg::MC_DTRSEL];

    // enable, feature and enhanced registers
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            interrupt_enable <= uart_irq_pkg::RST_ZERO;
            feature_control  <= uart_irq_pkg::RST_ZERO;
            enhanced_feature <= uart_irq_pkg::RST_ZERO;
            tx_trigger_prog  <= uart_irq_pkg::RST_ZERO;
        end else begin
            if (wr_en) begin
                // bit 4 reserved; upper bits only with enhanced on
                interrupt_enable[3:0] <= wdata_i[3:0];
                interrupt_enable[4]   <= 1'b0;
                if (enh) begin
                    interrupt_enable[7:5] <= wdata_i[7:5];
                end
            end
            if (wr_feat) begin
                feature_control <= wdata_i;
            end
            if (wr_enh) begin
                enhanced_feature <= wdata_i;
            end
            if (wr_trg) begin
                tx_trigger_prog <= wdata_i;
            end
        end
    end

    // fifo control register; write-only, reset bits pulse one cycle
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            fifo_en_o     <= 1'b0;
            rx_fifo_rst_o <= 1'b0;
            tx_fifo_rst_o <= 1'b0;
            block_mode_o  <= 1'b0;
            tx_trig_sel_o <= 2'h0;
            trig_table_o  <= 2'h0;
        end else begin
            rx_fifo_rst_o <= 1'b0;
            tx_fifo_rst_o <= 1'b0;
            if (wr_feat) begin
                trig_table_o <= wdata_i[uart_irq_pkg::FT_TBL_L +: 2];
            end
            if (wr_fc) begin
                fifo_en_o <= wdata_i[uart_irq_pkg::FC_EN];
                if (wdata_i[uart_irq_pkg::FC_EN]) begin
                    rx_fifo_rst_o <= wdata_i[uart_irq_pkg::FC_RXRST];
                    tx_fifo_rst_o <= wdata_i[uart_irq_pkg::FC_TXRST];
                    block_mode_o  <= wdata_i[uart_irq_pkg::FC_BLOCK];
                    if (enh) begin
                        tx_trig_sel_o <= wdata_i[uart_irq_pkg::FC_TXTRG_L +: 2];
                        trig_table_o  <= feature_control[uart_irq_pkg::FT_TBL_L +: 2];
                    end
                end
            end
        end
    end

    // transmit trigger from the shared table
    always_comb begin
        case ({trig_table_o, tx_trig_sel_o})
            4'h4:    tx_trigger = 7'd16;
            4'h5:    tx_trigger = 7'd8;
            4'h6:    tx_trigger = 7'd24;
            4'h7:    tx_trigger = 7'd30;
            4'h8:    tx_trigger = 7'd8;
            4'h9:    tx_trigger = 7'd16;
            4'ha:    tx_trigger = 7'd32;
            4'hb:    tx_trigger = 7'd56;
            4'hc, 4'hd, 4'he, 4'hf: tx_trigger = tx_trigger_prog[6:0];
            default: tx_trigger = 7'd1;
        endcase
    end

    // remembers whether the last reload pushed the fifo past the trigger
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            tx_reloaded_over <= 1'b0;
        end else if (tx_level_i > tx_trigger) begin
            tx_reloaded_over <= 1'b1;
        end else if (tx_level_i == 7'h00) begin
            tx_reloaded_over <= 1'b0;
        end
    end

    // transmit ready: rising edge, set wins over the status-read clear
    logic tx_cond;
    always_comb begin
        if (feature_control[uart_irq_pkg::FT_HDX]) begin
            tx_cond = tx_hold_empty_i && tx_shift_empty_i && tx_level_i == 7'h00;
        end else if (fifo_en_o) begin
            tx_cond = (tx_reloaded_over && tx_level_i < tx_trigger) || tx_level_i == 7'h00;
        end else begin
            tx_cond = tx_hold_empty_i;
        end
    end
    logic tx_cond_q;
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            tx_cond_q <= 1'b1;
            tx_pend   <= 1'b0;
        end else begin
            tx_cond_q <= tx_cond;
            if (tx_cond && !tx_cond_q) begin
                tx_pend <= 1'b1;
            end else if (rd_status && next_code == uart_irq_pkg::CODE_TX) begin
                tx_pend <= 1'b0;
            end
        end
    end

    // line status and modem status flags
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            line_pend  <= 1'b0;
            modem_pend <= 1'b0;
        end else begin
            if (rx_char_i && |line_err_i) begin
                line_pend <= 1'b1;
            end else if (rd_line) begin
                line_pend <= 1'b0;
            end
            if (|modem_delta_i) begin
                modem_pend <= 1'b1;
            end else if (rd_modem) begin
                modem_pend <= 1'b0;
            end
        end
    end

    // flow-control pin rising edges on the rts_dtr_sel_i and cts_dsr_sel_i inputs as given
    logic rts_now, cts_now, rts_rise, cts_rise;
    assign rts_now  = rts_dtr_sel_i;
    assign cts_now  = cts_dsr_sel_i;
    assign rts_rise = rts_now && !rts_q && enhanced_feature[uart_irq_pkg::EF_AUTORTS];
    assign cts_rise = cts_now && !cts_q && enhanced_feature[uart_irq_pkg::EF_AUTOCTS];
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            rts_q    <= 1'b0;
            cts_q    <= 1'b0;
            pin_pend <= 1'b0;
        end else begin
            rts_q <= rts_now;
            cts_q <= cts_now;
            if ((rts_rise && interrupt_enable[uart_irq_pkg::IE_RTS])
                || (cts_rise && interrupt_enable[uart_irq_pkg::IE_CTS])) begin
                pin_pend <= 1'b1;
            end else if (rd_modem) begin
                pin_pend <= 1'b0;
            end
        end
    end

    // xon/xoff/special character flag and last-seen indicator
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            char_pend           <= 1'b0;
            xonoff_kind         <= 1'b0;
            flow_char_indicator <= 2'h0;
        end else begin
            if (xon_det_i || xoff_det_i) begin
                char_pend           <= 1'b1;
                xonoff_kind         <= 1'b1;
                flow_char_indicator <= {xon_det_i, xoff_det_i};
            end else if (special_det_i) begin
                char_pend   <= 1'b1;
                xonoff_kind <= 1'b0;
            end else if (rd_status && next_code == uart_irq_pkg::CODE_CHAR) begin
                char_pend <= 1'b0;
            end else if (rx_char_i && !xonoff_kind) begin
                char_pend <= 1'b0;
            end else if (rd_flow) begin
                flow_char_indicator <= 2'h0; // self-clears after read
            end
        end
    end

    // receive timeout counter in bit ticks
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            to_cnt  <= 6'h00;
            to_pend <= 1'b0;
        end else begin
            if (rx_char_i || rd_line || rx_level_i == 7'h00 || rx_level_i >= rx_trigger_i) begin
                to_cnt <= 6'h00;
            end else if (bit_tick_i && to_cnt != uart_irq_pkg::TIMEOUT_TICKS) begin
                to_cnt <= to_cnt + 6'h01;
            end
            if (fifo_en_o && to_cnt == uart_irq_pkg::TIMEOUT_TICKS - 6'h01 && bit_tick_i
                && rx_level_i != 7'h00 && rx_level_i < rx_trigger_i) begin
                to_pend <= 1'b1;
            end else if (rx_level_i == 7'h00) begin
                to_pend <= 1'b0;
            end
        end
    end

    // wake-up indicator, cleared by the global source read
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            wake_flag_o <= 1'b0;
        end else if (wake_i) begin
            wake_flag_o <= 1'b1;
        end else if (global_src_rd_i) begin
            wake_flag_o <= 1'b0;
        end
    end

    // priority encoder over enabled pending sources
    logic rx_ready_irq_lvl;
    assign rx_ready_irq_lvl = interrupt_enable[0] && (fifo_en_o ? rx_level_i >= rx_trigger_i : rx_data_rdy_i);
    always_comb begin
        if (interrupt_enable[uart_irq_pkg::IE_LINE] && line_pend) begin
            next_code = uart_irq_pkg::CODE_LINE;
        end else if (rx_ready_irq_lvl) begin
            next_code = uart_irq_pkg::CODE_RX_READY_IRQ;
        end else if (interrupt_enable[0] && to_pend) begin
            next_code = uart_irq_pkg::CODE_RXTO;
        end else if (interrupt_enable[uart_irq_pkg::IE_TX] && tx_pend) begin
            next_code = uart_irq_pkg::CODE_TX;
        end else if (interrupt_enable[uart_irq_pkg::IE_MODEM] && modem_pend) begin
            next_code = uart_irq_pkg::CODE_MODEM;
        end else if (enh && interrupt_enable[uart_irq_pkg::IE_XOFF] && char_pend) begin
            next_code = uart_irq_pkg::CODE_CHAR;
        end else if (enh && pin_pend) begin
            next_code = uart_irq_pkg::CODE_PIN;
        end else begin
            next_code = uart_irq_pkg::CODE_NONE;
        end
    end

    // channel interrupt request
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            chan_irq_o <= 1'b0;
        end else begin
            chan_irq_o <= next_code != uart_irq_pkg::CODE_NONE;
        end
    end

    // read data, one cycle after the strobe; unmapped reads as zero
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            rdata_o <= uart_irq_pkg::RST_ZERO;
        end else if (rd_i) begin
            case (addr_i)
                uart_irq_pkg::ADDR_ENABLE:    rdata_o <= interrupt_enable;
                uart_irq_pkg::ADDR_STATUS_FC: rdata_o <= {{2{fifo_en_o}}, next_code};
                uart_irq_pkg::ADDR_FEATURE:   rdata_o <= feature_control;
                uart_irq_pkg::ADDR_ENHANCED:  rdata_o <= enhanced_feature;
                uart_irq_pkg::ADDR_FLOW_CHAR: rdata_o <= {6'h00, flow_char_indicator};
                uart_irq_pkg::ADDR_TX_LEVEL:  rdata_o <= {1'b0, tx_level_i};
                default:                      rdata_o <= uart_irq_pkg::RST_ZERO;
            endcase
        end else begin
            rdata_o <= uart_irq_pkg::RST_ZERO;
        end
    end

endmodule

// ### core/uart_irq_pkg.sv
// Purpose: constants for the channel interrupt and fifo control block
// Assumes: registers reached over a plain address/strobe port
// Notes:   offsets are local to this block
package uart_irq_pkg;
    // register offsets
    localparam logic [3:0] ADDR_ENABLE     = 4'h1;
    localparam logic [3:0] ADDR_STATUS_FC  = 4'h2;  // read status, write fifo control
    localparam logic [3:0] ADDR_LINE_STAT  = 4'h5;
    localparam logic [3:0] ADDR_MODEM_STAT = 4'h6;
    localparam logic [3:0] ADDR_FEATURE    = 4'h8;
    localparam logic [3:0] ADDR_ENHANCED   = 4'h9;
    localparam logic [3:0] ADDR_FLOW_CHAR  = 4'hc;
    localparam logic [3:0] ADDR_TX_LEVEL   = 4'ha;
    localparam logic [3:0] ADDR_TX_TRIG    = 4'hb;
    // enable register bits
    localparam int IE_TX    = 1;
    localparam int IE_LINE  = 2;
    localparam int IE_MODEM = 3;
    localparam int IE_XOFF  = 5;
    localparam int IE_RTS   = 6;
    localparam int IE_CTS   = 7;
    // fifo control bits
    localparam int FC_EN      = 0;
    localparam int FC_RXRST   = 1;
    localparam int FC_TXRST   = 2;
    localparam int FC_BLOCK   = 3;
    localparam int FC_TXTRG_L = 4;
    // feature / enhanced / modem control bits
    localparam int FT_HDX     = 5;
    localparam int FT_TBL_L   = 6;
    localparam int EF_ENH     = 4;
    localparam int EF_AUTORTS = 6;
    localparam int EF_AUTOCTS = 7;
    localparam int MC_DTRSEL  = 2;
    // status codes, bits 5:0
    localparam logic [5:0] CODE_LINE  = 6'h06;
    localparam logic [5:0] CODE_RX_READY_IRQ = 6'h04;
    localparam logic [5:0] CODE_RXTO  = 6'h0c;
    localparam logic [5:0] CODE_TX    = 6'h02;
    localparam logic [5:0] CODE_MODEM = 6'h00;
    localparam logic [5:0] CODE_CHAR  = 6'h10;
    localparam logic [5:0] CODE_PIN   = 6'h20;
    localparam logic [5:0] CODE_NONE  = 6'h01;
    // reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    // receive timeout: 4 characters plus 12 bit times, counted in bit ticks
    localparam int CHAR_BITS     = 10;
    localparam int TIMEOUT_BITS  = 4 * CHAR_BITS + 12;
    localparam logic [5:0] TIMEOUT_TICKS = 6'(TIMEOUT_BITS);
    // fifo depth
    localparam logic [6:0] FIFO_DEPTH = 7'h40;
endpackage

// ### testbench/uart_irq_ctrl_properties.sv
// Purpose: port-level checks of the channel interrupt and fifo control block
// Assumes: one clock, synchronous active-low reset, read data one cycle after rd_i
// Notes:   status field checks need no knowledge of which source is pending
`timescale 1ns/1ps
module uart_irq_ctrl_checker (
    // clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rstn_i,
    // register port
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic [7:0] rdata_o,
    // wake events
    input  wire logic       wake_i,
    input  wire logic       global_src_rd_i,
    // fifo control and flags
    input  wire logic       fifo_en_o,
    input  wire logic       rx_fifo_rst_o,
    input  wire logic       tx_fifo_rst_o,
    input  wire logic       block_mode_o,
    input  wire logic [1:0] trig_table_o,
    input  wire logic       wake_flag_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    localparam logic [3:0] FC = uart_irq_pkg::ADDR_STATUS_FC;
    // status read and an accepted fifo control write
    sequence s_stat_rd; rd_i && addr_i == FC; endsequence
    sequence s_fc_wr; wr_i && addr_i == FC && wdata_i[0]; endsequence
    property p_fen_bits; s_stat_rd |=> rdata_o[7:6] == {2{fifo_en_o}}; endproperty
    a_fen_bits: assert property (p_fen_bits) else $error("status 7:6 wrong");
    property p_idle_bit; s_stat_rd |=> rdata_o[0] == (rdata_o[5:0] == uart_irq_pkg::CODE_NONE); endproperty
    a_idle_bit: assert property (p_idle_bit) else $error("status bit 0 wrong");
    property p_code_set;
        s_stat_rd |=> rdata_o[5:0] inside {6'h06, 6'h04, 6'h0c, 6'h02, 6'h00, 6'h10, 6'h20, 6'h01};
    endproperty
    a_code_set: assert property (p_code_set) else $error("bad status code");
    property p_rx_rst; s_fc_wr ##0 wdata_i[1] |=> rx_fifo_rst_o; endproperty
    a_rx_rst: assert property (p_rx_rst) else $error("rx reset missing");
    // self clearing: a lone pulse drops after one cycle
    property p_rx_once; rx_fifo_rst_o && !wr_i |=> !rx_fifo_rst_o; endproperty
    a_rx_once: assert property (p_rx_once) else $error("rx reset stuck");
    property p_tx_quiet; !(wr_i && addr_i == FC && wdata_i[0] && wdata_i[2]) |=> !tx_fifo_rst_o; endproperty
    a_tx_quiet: assert property (p_tx_quiet) else $error("stray tx reset");
    property p_fen_wr; wr_i && addr_i == FC |=> fifo_en_o == $past(wdata_i[0]); endproperty
    a_fen_wr: assert property (p_fen_wr) else $error("fifo enable not bit 0");
    property p_fen_hold; !wr_i |=> $stable(fifo_en_o); endproperty
    a_fen_hold: assert property (p_fen_hold) else $error("fifo enable moved");
    property p_block; s_fc_wr |=> block_mode_o == $past(wdata_i[3]); endproperty
    a_block: assert property (p_block) else $error("block bit not stored");
    property p_table; wr_i && addr_i == uart_irq_pkg::ADDR_FEATURE |=> trig_table_o == $past(wdata_i[7:6]); endproperty
    a_table: assert property (p_table) else $error("table not updated");
    property p_wake; wake_i || global_src_rd_i |=> wake_flag_o == $past(wake_i); endproperty
    a_wake: assert property (p_wake) else $error("wake flag wrong");
endmodule

bind uart_irq_ctrl uart_irq_ctrl_checker u_chk (.*);

// ### testbench/line_side_model.sv
// Purpose: datapath and serial side model feeding the interrupt block
// Assumes: bench calls ev and lv; changes land just after a rising edge
// Notes:   error bits carry garbage outside a character strobe
`timescale 1ns/1ps
module line_side_model (
    // clock
    input  wire logic       sys_clk_i,
    // receive side
    output logic      [4:1] line_err_o,
    output logic            rx_char_o,
    output logic            rx_data_rdy_o,
    output logic      [6:0] rx_level_o,
    output logic      [6:0] rx_trigger_o,
    output logic            bit_tick_o,
    // transmit side
    output logic            tx_hold_empty_o,
    output logic      [6:0] tx_level_o,
    output logic            tx_shift_empty_o,
    // modem and flow pins
    output logic      [3:0] modem_delta_o,
    output logic            rts_dtr_sel_o,
    output logic            cts_dsr_sel_o,
    output logic      [7:0] modem_control_o,
    // detectors and global logic
    output logic            xon_det_o,
    output logic            xoff_det_o,
    output logic            special_det_o,
    output logic            wake_o,
    output logic            global_src_rd_o
);
    logic [10:0] pulse = 11'h000;
    logic [3:0]  err   = 4'h0;
    // one-cycle event strobes
    assign {modem_delta_o, global_src_rd_o, wake_o, special_det_o, xoff_det_o, xon_det_o, bit_tick_o, rx_char_o} = pulse;
    // inverted last value between characters, so stray sampling shows up
    assign line_err_o = rx_char_o ? err : ~err;
    task automatic ev(input logic [10:0] p, input logic [3:0] e);
        @(posedge sys_clk_i);
        pulse <= p;
        err   <= e;
        @(posedge sys_clk_i);
        pulse <= 11'h000;
        #1;
    endtask
    // levels: rx level, rx trigger, tx level; flags: hold, shift, rts, cts
    task automatic lv(input logic [20:0] l, input logic [3:0] f);
        @(posedge sys_clk_i);
        {rx_level_o, rx_trigger_o, tx_level_o} <= l;
        {tx_hold_empty_o, tx_shift_empty_o, rts_dtr_sel_o, cts_dsr_sel_o} <= f;
        repeat (2) @(posedge sys_clk_i);
    endtask
    // full tx fifo, nothing received, pins low
    initial begin
        {rx_level_o, rx_trigger_o, tx_level_o} = {7'h00, 7'h01, 7'h40};
        {tx_hold_empty_o, tx_shift_empty_o, rts_dtr_sel_o, cts_dsr_sel_o} = 4'h0;
        rx_data_rdy_o   = 1'b0;
        modem_control_o = 8'h00;
    end
endmodule

// ### testbench/tb.sv
// Purpose: register level tests of the channel interrupt and fifo control block
// Assumes: one-cycle strobes
// Notes:   the 52 tick receive timer is run in full, it is short
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_fail++; $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module tb;
    localparam logic [3:0] S = uart_irq_pkg::ADDR_STATUS_FC;
    localparam logic [3:0] E = uart_irq_pkg::ADDR_ENABLE;
    localparam logic [3:0] H = uart_irq_pkg::ADDR_ENHANCED;
    localparam logic [3:0] F = uart_irq_pkg::ADDR_FEATURE;
    localparam logic [3:0] M = uart_irq_pkg::ADDR_MODEM_STAT;
    // register port driven here
    logic       sys_clk_i = 1'b0;
    logic       rstn_i    = 1'b0;
    logic [3:0] addr_i    = 4'h0;
    logic [7:0] wdata_i   = 8'h00;
    logic       wr_i      = 1'b0;
    logic       rd_i      = 1'b0;
    // datapath wires and outputs
    logic [7:0] rdata_o, modem_control_i;
    logic [6:0] rx_level_i, rx_trigger_i, tx_level_i;
    logic [4:1] line_err_i;
    logic [3:0] modem_delta_i;
    logic [1:0] trig_table_o, tx_trig_sel_o;
    logic       rx_char_i, rx_data_rdy_i, bit_tick_i, tx_hold_empty_i, tx_shift_empty_i, rts_dtr_sel_i;
    logic       cts_dsr_sel_i, xon_det_i, xoff_det_i, special_det_i, wake_i, global_src_rd_i;
    logic       fifo_en_o, rx_fifo_rst_o, tx_fifo_rst_o, block_mode_o, chan_irq_o, wake_flag_o;
    int         n_fail  = 0;
    int         checked = 0;
    uart_irq_ctrl DUT (.*);
    line_side_model peer (.sys_clk_i, .line_err_o(line_err_i), .rx_char_o(rx_char_i), .rx_data_rdy_o(rx_data_rdy_i),
        .rx_level_o(rx_level_i), .rx_trigger_o(rx_trigger_i), .bit_tick_o(bit_tick_i),
        .tx_hold_empty_o(tx_hold_empty_i), .tx_level_o(tx_level_i), .tx_shift_empty_o(tx_shift_empty_i),
        .modem_delta_o(modem_delta_i), .rts_dtr_sel_o(rts_dtr_sel_i), .cts_dsr_sel_o(cts_dsr_sel_i),
        .modem_control_o(modem_control_i), .xon_det_o(xon_det_i), .xoff_det_o(xoff_det_i),
        .special_det_o(special_det_i), .wake_o(wake_i), .global_src_rd_o(global_src_rd_i));
    // 200 MHz
    always #2.5 sys_clk_i = ~sys_clk_i;
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    // sample in the one cycle the data stand; mask 0 only clears
    task automatic rd(input logic [3:0] a, input logic [7:0] ex, input string nm, input logic [7:0] m = 8'hff);
        @(posedge sys_clk_i);
        {addr_i, rd_i} <= {a, 1'b1};
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        `CHK(nm, ex, rdata_o & m)
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        rd(S, 8'h01, "status after reset");
        rd(4'h3, 8'h00, "unmapped");
        wr(E, 8'he0);
        rd(E, 8'h00, "enable without enh");
        wr(S, 8'h0f);
        `CHK("block on", 1'b1, block_mode_o)
        rd(S, 8'hc1, "fifo on status");
        wr(S, 8'h08);
        `CHK("fifo off", 1'b0, fifo_en_o)
        `CHK("block kept", 1'b1, block_mode_o)
        wr(S, 8'h31);
        `CHK("trig sel locked", 2'h0, tx_trig_sel_o)
        wr(H, 8'h10);
        wr(S, 8'h31);
        `CHK("trig sel", 2'h3, tx_trig_sel_o)
        `CHK("block off", 1'b0, block_mode_o)
        wr(F, 8'hc0);
        `CHK("table 3", 2'h3, trig_table_o)
        wr(F, 8'h40);
        `CHK("table 1", 2'h1, trig_table_o)
        wr(E, 8'hff);
        rd(E, 8'hef, "enable with enh");
        // errored character and modem change together
        peer.ev(11'h401, 4'h2);
        rd(S, 8'hc6, "line first");
        `CHK("irq up", 1'b1, chan_irq_o)
        rd(S, 8'hc6, "line held");
        rd(uart_irq_pkg::ADDR_LINE_STAT, 8'h00, "line read", 8'h00);
        rd(S, 8'hc0, "modem next");
        rd(M, 8'h00, "modem read", 8'h00);
        rd(S, 8'hc1, "none left");
        `CHK("irq down", 1'b0, chan_irq_o)
        // fifo reloaded to 64, now drains below the trigger of 30
        peer.lv({7'h00, 7'h01, 7'h10}, 4'h8);
        rd(S, 8'hc2, "tx ready");
        rd(S, 8'hc1, "tx cleared");
        peer.lv({7'h00, 7'h01, 7'h40}, 4'h0);
        wr(F, 8'h60);
        peer.lv({7'h00, 7'h01, 7'h40}, 4'h8);
        rd(S, 8'hc1, "hdx hold only");
        peer.lv({7'h00, 7'h01, 7'h00}, 4'hc);
        rd(S, 8'hc2, "hdx all empty");
        wr(F, 8'h40);
        peer.ev(11'h004, 4'h0);
        rd(S, 8'hd0, "xon");
        rd(S, 8'hc1, "xon cleared");
        peer.ev(11'h010, 4'h0);
        rd(S, 8'hd0, "special");
        peer.ev(11'h010, 4'h0);
        peer.ev(11'h001, 4'h0);
        rd(S, 8'hc1, "special by char");
        wr(H, 8'h00);
        peer.ev(11'h008, 4'h0);
        rd(S, 8'hc1, "xoff without enh");
        wr(H, 8'hd0);
        rd(S, 8'hd0, "xoff shown with enh");
        wr(E, 8'hff);
        peer.lv({7'h00, 7'h01, 7'h00}, 4'hd);
        rd(S, 8'he0, "cts rise");
        rd(M, 8'h00, "modem read", 8'h00);
        peer.lv({7'h00, 7'h01, 7'h00}, 4'hf);
        rd(S, 8'he0, "rts rise");
        rd(M, 8'h00, "modem read", 8'h00);
        rd(S, 8'hc1, "pins cleared");
        // receive timer: one short of the limit, then the last tick
        peer.lv({7'h01, 7'h08, 7'h00}, 4'hf);
        repeat (uart_irq_pkg::TIMEOUT_BITS - 1) peer.ev(11'h002, 4'h0);
        rd(S, 8'hc1, "timer early");
        peer.ev(11'h002, 4'h0);
        for (int i = 0; i < 8 && chan_irq_o !== 1'b1; i++) @(posedge sys_clk_i);
        `CHK("timeout irq", 1'b1, chan_irq_o)
        if (chan_irq_o !== 1'b1) results();
        rd(S, 8'hcc, "timeout");
        peer.lv({7'h00, 7'h08, 7'h00}, 4'hf);
        rd(S, 8'hc1, "timeout emptied");
        peer.lv({7'h08, 7'h08, 7'h00}, 4'hf);
        rd(S, 8'hc4, "rx ready");
        peer.lv({7'h07, 7'h08, 7'h00}, 4'hf);
        rd(S, 8'hc1, "rx below trigger");
        peer.ev(11'h020, 4'h0);
        `CHK("wake set", 1'b1, wake_flag_o)
        peer.ev(11'h040, 4'h0);
        `CHK("wake cleared", 1'b0, wake_flag_o)
        results();
    end
endmodule
